// >>> rtl/srcs_regs.svh
/*
 * Constants of the reset and clock sequencer: register offsets, field
 * positions, reset values and cycle counts.
 * Assumes inclusion by its bare name from the top module.
 */
`ifndef SRCS_REGS_SVH
`define SRCS_REGS_SVH

`define SRCS_CNT_W 12
`define SRCS_OSC_WAIT_CYC 4096
`define SRCS_STOP_SHORT_CYC 32
`define SRCS_PHASE_CYC 32
`define SRCS_PIN_QUAL_LONG_CYC 4163
`define SRCS_PIN_QUAL_CYC 67
`define SRCS_BUS_DIV 4

`define SRCS_ADDR_CTRL 4'h0
`define SRCS_ADDR_OPTION 4'h4
`define SRCS_ADDR_CAUSE 4'h8
`define SRCS_ADDR_STATUS 4'hC

`define SRCS_CTRL_PLL_SEL 0
`define SRCS_OPT_WD_DIS 0
`define SRCS_OPT_LV_PWR_OFF 1
`define SRCS_OPT_LV_RST_DIS 2
`define SRCS_OPT_SHORT_STOP 3
`define SRCS_OPT_STOP_EN 4
`define SRCS_OPT_RESET 5'h00

`define SRCS_CAUSE_POR 0
`define SRCS_CAUSE_PIN 1
`define SRCS_CAUSE_WDOG 2
`define SRCS_CAUSE_OPCODE 3
`define SRCS_CAUSE_FETCH 4
`define SRCS_CAUSE_MON 5
`define SRCS_CAUSE_LV 6
`define SRCS_CAUSE_RESET 7'h01

`define SRCS_VEC_USER 16'hFFFE
`define SRCS_VEC_MONITOR 16'hFEFE
`define SRCS_RESP_OKAY 2'h0
`define SRCS_RESP_SLVERR 2'h2

`endif

// >>> rtl/srcs_pkg.sv
/*
 * Types of the reset and clock sequencer.
 * Assumes nothing beyond the constants header.
 */
package srcs_pkg;
    typedef enum logic [2:0] {
        ST_OSC = 3'h7,
        ST_PIN = 3'h6,
        ST_HOLD = 3'h2,
        ST_RUN = 3'h0,
        ST_STOP = 3'h1,
        ST_STOP_REC = 3'h3,
        ST_EXT_LOW = 3'h4,
        ST_LV_LOW = 3'h5
    } srcs_state_t;
endpackage

// >>> rtl/srcs_cnt_if.sv
/*
 * Carrier between the sequencer and its free-running counter.
 * Assumes one controller and one counter on the same clock.
 */
`timescale 1ns/1ps
interface srcs_cnt_if #(
    parameter int W = 12
);
    logic clr;
    logic [W-1:0] cnt;
    logic ovf;
    modport ctl (output clr, input cnt, input ovf);
    modport counter (input clr, output cnt, output ovf);
endinterface

// >>> rtl/srcs_cnt.sv
/*
 * Free-running counter with synchronous clear and an overflow pulse.
 * Assumes the clear comes from logic on the same clock.
 */
`timescale 1ns/1ps
module srcs_cnt (
    input wire logic i_clk,
    input wire logic i_reset_n,
    srcs_cnt_if.counter cif
);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cif.cnt <= '0;
        end else if (cif.clr) begin
            cif.cnt <= '0;
        end else begin
            cif.cnt <= cif.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cif.ovf <= 1'b0;
        end else begin
            cif.ovf <= !cif.clr && (&cif.cnt);
        end
    end
endmodule // srcs_cnt

// >>> rtl/srcs_top.sv
/*
 * Reset and bus clock sequencer: reset sources, reset pin, cause flags,
 * 12-bit stabilization counter, stop recovery and bus clock enable.
 * Assumes all inputs except the watchdog request and the reset pin are synchronous to I_CLK,
 * which is the reference clock; AXI4-Lite master on the same clock.
 */
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "srcs_regs.svh"
module srcs_top
    import srcs_pkg::*;
#(
    parameter int P_OSC_WAIT = `SRCS_OSC_WAIT_CYC,
    parameter int P_STOP_SHORT = `SRCS_STOP_SHORT_CYC,
    parameter int P_PIN_QUAL_LONG = `SRCS_PIN_QUAL_LONG_CYC,
    parameter int P_PIN_QUAL = `SRCS_PIN_QUAL_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_POR,
    input wire logic I_PLL_TICK,
    input wire logic I_RST_PIN_I,
    output logic O_RST_PIN_O,
    output logic O_RST_PIN_OE_N,
    input wire logic I_WDOG_REQ,
    input wire logic I_BAD_OPCODE,
    input wire logic I_STOP_EXEC,
    input wire logic I_STOP_WAKE,
    input wire logic I_OPCODE_FETCH,
    input wire logic I_UNMAPPED_ADDR,
    input wire logic I_LV_DETECT,
    input wire logic I_MON_ENTRY_RESET,
    input wire logic I_MONITOR_MODE,
    input wire logic I_BREAK_STATE,
    input wire logic I_TEST_HV_RST,
    input wire logic I_TEST_HV_IRQ,
    output logic O_INTERNAL_RESET,
    output logic O_CPU_CLK_EN,
    output logic O_PERIPH_CLK_EN,
    output logic O_CLOCK_GEN_OUTPUT_EN,
    output logic O_WDOG_CLK_EN,
    output logic O_WDOG_ENABLE,
    output logic [15:0] O_RESET_VECTOR,
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    localparam int CW = `SRCS_CNT_W;
    localparam logic [CW-1:0] OSC_END = CW'(P_OSC_WAIT - 1);
    localparam logic [CW-1:0] SHORT_END = CW'(P_STOP_SHORT - 1);
    localparam logic [5:0] PHASE_END = 6'(`SRCS_PHASE_CYC - 1);
    localparam logic [12:0] QUAL_LONG = 13'(P_PIN_QUAL_LONG - 1);
    localparam logic [12:0] QUAL_SHORT = 13'(P_PIN_QUAL - 1);

    srcs_state_t state_reg, state_next;
    logic pin_s1_reg, pin_s2_reg, wd_s1_reg, wd_s2_reg, oe_d1_reg, oe_d2_reg;
    logic boot_reg, long_seq_reg, short_stop_recovery_reg, pll_sel_reg, clkgen_reg;
    logic [1:0] div_reg;
    logic [5:0] phase_reg;
    logic [12:0] pin_cnt_reg;
    logic [4:0] opt_reg;
    logic [6:0] cause_reg, cause_set, cause_clr;
    logic por_trig, lv_trig, wd_trig, op_trig, ad_trig, mon_trig, int_trig;
    logic stop_ok, wd_en, ext_low, pin_qual, src_tick, bus_tick, clocks_on;
    logic internal_reset, phase_clr;
    logic aw_have, w_have;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;

    srcs_cnt_if #(.W(CW)) cnt_bus ();

    srcs_cnt u_cnt (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .cif(cnt_bus)
    );

    // Two-stage synchronisers, first stage read only by the second
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            wd_s1_reg <= 1'b0;
            wd_s2_reg <= 1'b0;
            oe_d1_reg <= 1'b0;
            oe_d2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= I_RST_PIN_I;
            pin_s2_reg <= pin_s1_reg;
            wd_s1_reg <= I_WDOG_REQ;
            wd_s2_reg <= wd_s1_reg;
            oe_d1_reg <= O_RST_PIN_OE_N;
            oe_d2_reg <= oe_d1_reg;
        end
    end

    // Reset sources
    always_comb begin
        wd_en = !opt_reg[`SRCS_OPT_WD_DIS]
            && !(I_MONITOR_MODE && (I_TEST_HV_RST || I_TEST_HV_IRQ))
            && !(I_BREAK_STATE && I_TEST_HV_RST);
        stop_ok = I_STOP_EXEC && opt_reg[`SRCS_OPT_STOP_EN];
        por_trig = I_POR || !boot_reg;
        lv_trig = I_LV_DETECT && !opt_reg[`SRCS_OPT_LV_PWR_OFF]
            && !opt_reg[`SRCS_OPT_LV_RST_DIS];
        wd_trig = wd_s2_reg && wd_en;
        op_trig = I_BAD_OPCODE || (I_STOP_EXEC && !opt_reg[`SRCS_OPT_STOP_EN]);
        ad_trig = I_OPCODE_FETCH && I_UNMAPPED_ADDR;
        mon_trig = I_MON_ENTRY_RESET;
        int_trig = wd_trig || op_trig || ad_trig || mon_trig;
        // Own drive lingers two cycles in the synchroniser after release
        ext_low = !pin_s2_reg && O_RST_PIN_OE_N && oe_d2_reg;
        pin_qual = !pin_s2_reg && !por_trig && !lv_trig && !int_trig
            && (pin_cnt_reg == (long_seq_reg ? QUAL_LONG : QUAL_SHORT));
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        phase_clr = 1'b0;
        if (por_trig) begin
            state_next = ST_OSC;
        end else if (lv_trig) begin
            state_next = ST_LV_LOW;
        end else if (int_trig) begin
            state_next = ST_PIN;
            phase_clr = 1'b1;
        end else begin
            case (state_reg)
                ST_OSC: begin
                    if (cnt_bus.cnt == OSC_END) begin
                        state_next = ST_PIN;
                        phase_clr = 1'b1;
                    end
                end
                ST_LV_LOW: begin
                    if (!I_LV_DETECT) begin
                        state_next = ST_OSC;
                    end
                end
                ST_PIN: begin
                    if (phase_reg == PHASE_END) begin
                        state_next = ST_HOLD;
                        phase_clr = 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (ext_low) begin
                        state_next = ST_EXT_LOW;
                    end else if (phase_reg == PHASE_END) begin
                        state_next = ST_RUN;
                    end
                end
                ST_EXT_LOW: begin
                    if (pin_s2_reg) begin
                        state_next = ST_HOLD;
                        phase_clr = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (ext_low) begin
                        state_next = ST_EXT_LOW;
                    end else if (stop_ok) begin
                        state_next = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (ext_low) begin
                        state_next = ST_EXT_LOW;
                    end else if (I_STOP_WAKE) begin
                        state_next = ST_STOP_REC;
                    end
                end
                ST_STOP_REC: begin
                    if (ext_low) begin
                        state_next = ST_EXT_LOW;
                    end else if (cnt_bus.cnt == (short_stop_recovery_reg ? SHORT_END : OSC_END)) begin
                        state_next = ST_RUN;
                    end
                end
                default: begin
                    state_next = ST_OSC;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg <= ST_OSC;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counter clear: internal resets, stop entry, held through stop
    always_comb begin
        cnt_bus.clr = por_trig || lv_trig || int_trig
            || state_reg == ST_LV_LOW || state_reg == ST_STOP
            || (state_reg == ST_RUN && stop_ok);
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            phase_reg <= '0;
        end else if (phase_clr) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_cnt_reg <= '0;
        end else if (pin_s2_reg) begin
            pin_cnt_reg <= '0;
        end else if (pin_cnt_reg != QUAL_LONG) begin
            pin_cnt_reg <= pin_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            boot_reg <= 1'b0;
            clkgen_reg <= 1'b0;
            long_seq_reg <= 1'b1;
            short_stop_recovery_reg <= 1'b0;
        end else begin
            boot_reg <= 1'b1;
            if (por_trig) begin
                clkgen_reg <= 1'b1;
            end
            if (por_trig || lv_trig) begin
                long_seq_reg <= 1'b1;
            end else if (state_reg == ST_RUN) begin
                long_seq_reg <= 1'b0;
            end
            if (state_reg == ST_STOP && I_STOP_WAKE) begin
                short_stop_recovery_reg <= opt_reg[`SRCS_OPT_SHORT_STOP];
            end
        end
    end

    // Reset cause flags: a new internal reset replaces, set wins over clear
    always_comb begin
        cause_set = '0;
        cause_set[`SRCS_CAUSE_POR] = por_trig;
        cause_set[`SRCS_CAUSE_PIN] = pin_qual;
        cause_set[`SRCS_CAUSE_WDOG] = wd_trig;
        cause_set[`SRCS_CAUSE_OPCODE] = op_trig;
        cause_set[`SRCS_CAUSE_FETCH] = ad_trig;
        cause_set[`SRCS_CAUSE_MON] = mon_trig;
        cause_set[`SRCS_CAUSE_LV] = lv_trig;
        cause_clr = (wr_fire && aw_addr == `SRCS_ADDR_CAUSE && w_strb[0])
            ? w_data[6:0] : 7'h00;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cause_reg <= `SRCS_CAUSE_RESET;
        end else if (por_trig || lv_trig || int_trig) begin
            cause_reg <= cause_set;
        end else begin
            cause_reg <= (cause_reg & ~cause_clr) | cause_set;
        end
    end

    // Bus clock: quarter of the selected source
    always_comb begin
        internal_reset = !(state_next == ST_RUN || state_next == ST_STOP
            || state_next == ST_STOP_REC);
        src_tick = pll_sel_reg ? I_PLL_TICK : 1'b1;
        bus_tick = src_tick && (div_reg == 2'(`SRCS_BUS_DIV - 1));
        clocks_on = state_next == ST_PIN || state_next == ST_HOLD
            || state_next == ST_EXT_LOW || state_next == ST_RUN;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            div_reg <= '0;
        end else if (internal_reset && !pll_sel_reg) begin
            div_reg <= div_reg + 1'b1;
        end else if (src_tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Outputs from flops
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_INTERNAL_RESET <= 1'b1;
            O_RST_PIN_OE_N <= 1'b0;
            O_CPU_CLK_EN <= 1'b0;
            O_PERIPH_CLK_EN <= 1'b0;
            O_WDOG_CLK_EN <= 1'b0;
            O_WDOG_ENABLE <= 1'b0;
            O_RESET_VECTOR <= `SRCS_VEC_USER;
        end else begin
            O_INTERNAL_RESET <= internal_reset;
            O_RST_PIN_OE_N <= !(state_next == ST_OSC || state_next == ST_LV_LOW
                || state_next == ST_PIN);
            O_CPU_CLK_EN <= bus_tick && clocks_on;
            O_PERIPH_CLK_EN <= bus_tick && clocks_on;
            O_WDOG_CLK_EN <= cnt_bus.ovf;
            O_WDOG_ENABLE <= wd_en;
            O_RESET_VECTOR <= I_MONITOR_MODE ? `SRCS_VEC_MONITOR : `SRCS_VEC_USER;
        end
    end

    assign O_RST_PIN_O = 1'b0;
    assign O_CLOCK_GEN_OUTPUT_EN = clkgen_reg;

    // AXI4-Lite write: address and data in either order
    assign AWREADY = !aw_have && !BVALID;
    assign WREADY = !w_have && !BVALID;
    assign wr_fire = aw_have && w_have && !BVALID;

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            BVALID <= 1'b0;
            BRESP <= `SRCS_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_have <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_have <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (aw_addr == `SRCS_ADDR_STATUS || aw_addr[1:0] != 2'h0)
                    ? `SRCS_RESP_SLVERR : `SRCS_RESP_OKAY;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Control and option registers; clock select returns to reference in reset
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pll_sel_reg <= 1'b0;
            opt_reg <= `SRCS_OPT_RESET;
        end else begin
            if (internal_reset) begin
                pll_sel_reg <= 1'b0;
            end else if (wr_fire && aw_addr == `SRCS_ADDR_CTRL && w_strb[0]) begin
                pll_sel_reg <= w_data[`SRCS_CTRL_PLL_SEL];
            end
            if (wr_fire && aw_addr == `SRCS_ADDR_OPTION && w_strb[0]) begin
                opt_reg <= w_data[4:0];
            end
        end
    end

    // AXI4-Lite read
    assign ARREADY = !RVALID;

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `SRCS_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= `SRCS_RESP_OKAY;
            case (ARADDR)
                `SRCS_ADDR_CTRL: RDATA <= {31'h0, pll_sel_reg};
                `SRCS_ADDR_OPTION: RDATA <= {27'h0, opt_reg};
                `SRCS_ADDR_CAUSE: RDATA <= {25'h0, cause_reg};
                `SRCS_ADDR_STATUS: RDATA <= {4'h0, cnt_bus.cnt, 12'h0,
                    O_INTERNAL_RESET, state_reg};
                default: begin
                    RDATA <= '0;
                    RRESP <= `SRCS_RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule // srcs_top

// >>> bench/srcs_monitor.sv
/* Checker on the sequencer top ports.
   Assumes binding onto srcs_top, all on I_CLK. */
`timescale 1ns/1ps
module srcs_monitor (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_RST_PIN_I,
    input wire logic I_BAD_OPCODE,
    input wire logic I_MONITOR_MODE,
    input wire logic I_TEST_HV_RST,
    input wire logic O_RST_PIN_OE_N,
    input wire logic O_INTERNAL_RESET,
    input wire logic O_CPU_CLK_EN,
    input wire logic O_WDOG_CLK_EN,
    input wire logic O_WDOG_ENABLE,
    input wire logic [15:0] O_RESET_VECTOR
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    property p_drive; !O_RST_PIN_OE_N |-> O_INTERNAL_RESET; endproperty
    a_drive: assert property (p_drive) else $error("pin driven outside reset");
    property p_hold;
        $rose(O_RST_PIN_OE_N) && I_RST_PIN_I |-> O_INTERNAL_RESET[*8] ##[20:30] !O_INTERNAL_RESET;
    endproperty
    a_hold: assert property (p_hold) else $error("bad reset tail");
    property p_div; O_CPU_CLK_EN |=> !O_CPU_CLK_EN[*3]; endproperty
    a_div: assert property (p_div) else $error("bus enable too often");
    property p_off; O_CPU_CLK_EN && !O_RST_PIN_OE_N |-> ##[1:32] O_RST_PIN_OE_N; endproperty
    a_off: assert property (p_off) else $error("bus clock in reset");
    property p_vec;
        $stable(I_MONITOR_MODE) |-> O_RESET_VECTOR == (I_MONITOR_MODE ? 16'hFEFE : 16'hFFFE);
    endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_hv; (I_MONITOR_MODE && I_TEST_HV_RST)[*3] |-> !O_WDOG_ENABLE; endproperty
    a_hv: assert property (p_hv) else $error("watchdog not off");
    property p_op; I_BAD_OPCODE && !O_INTERNAL_RESET |-> ##[1:2] !O_RST_PIN_OE_N; endproperty
    a_op: assert property (p_op) else $error("no opcode reset");
    property p_wdclk; O_WDOG_CLK_EN |=> !O_WDOG_CLK_EN[*8]; endproperty
    a_wdclk: assert property (p_wdclk) else $error("watchdog tick too often");
    c_pin: cover property (!I_RST_PIN_I && O_RST_PIN_OE_N);
    c_wdclk: cover property (O_WDOG_CLK_EN);
    c_hv: cover property (I_MONITOR_MODE && I_TEST_HV_RST);
endmodule // srcs_monitor
bind srcs_top srcs_monitor srcs_monitor_inst (.*);

// >>> bench/srcs_far_end.sv
/* Far side: reset line with pullup, and a PLL tick source.
   Assumes the device drives the line only while its enable is low. */
`timescale 1ns/1ps
module srcs_far_end (
    input wire logic i_clk,
    input wire logic i_pll_run,
    input wire logic i_pull_low,
    input wire logic i_pin_o,
    input wire logic i_pin_oe_n,
    output logic o_pin,
    output logic o_pll_tick
);
    // Device drive wins, then the outside party, then the pullup
    assign o_pin = !i_pin_oe_n ? i_pin_o : !i_pull_low;
    always_ff @(posedge i_clk) begin
        o_pll_tick <= i_pll_run && !o_pll_tick;
    end
endmodule // srcs_far_end

// >>> bench/system_reset_clock_sequencer_tb.sv
/* Bench: AXI4-Lite tasks and a table of reset sources.
   Assumes srcs_top with a 64-cycle power-on wait. */
`timescale 1ns/1ps
module system_reset_clock_sequencer_tb;
    logic I_CLK, I_RESET_N, I_POR, I_PLL_TICK, I_RST_PIN_I, O_RST_PIN_O, O_RST_PIN_OE_N;
    logic I_WDOG_REQ, I_BAD_OPCODE, I_STOP_EXEC, I_STOP_WAKE, I_OPCODE_FETCH, I_UNMAPPED_ADDR;
    logic I_LV_DETECT, I_MON_ENTRY_RESET, I_MONITOR_MODE, I_BREAK_STATE, I_TEST_HV_RST;
    logic I_TEST_HV_IRQ, O_INTERNAL_RESET, O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_CLOCK_GEN_OUTPUT_EN;
    logic O_WDOG_CLK_EN, O_WDOG_ENABLE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, pll_run, pull_low;
    logic [15:0] O_RESET_VECTOR;
    logic [3:0] AWADDR, ARADDR, WSTRB;
    logic [31:0] WDATA, RDATA, rd_data;
    logic [1:0] BRESP, RRESP, resp;
    logic [7:0] src;
    int errors = 0, total_checks = 0, n;
    localparam logic [7:0] HIT [6] = '{8'h01, 8'h02, 8'h24, 8'h08, 8'h10, 8'h40};
    localparam logic [7:0] CAUSE [6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h08, 8'h40};
    localparam logic [7:0] OPT_S [4] = '{8'h01, 8'h00, 8'h04, 8'h02};
    localparam logic [7:0] HIT_S [4] = '{8'h01, 8'h20, 8'h40, 8'h40};
    assign {I_STOP_WAKE, I_LV_DETECT, I_UNMAPPED_ADDR, I_STOP_EXEC, I_MON_ENTRY_RESET,
        I_OPCODE_FETCH, I_BAD_OPCODE, I_WDOG_REQ} = src;
    srcs_top #(.P_OSC_WAIT(64), .P_PIN_QUAL_LONG(100)) srcs_top_inst (.*);
    srcs_far_end srcs_far_end_inst (.i_clk(I_CLK), .i_pll_run(pll_run), .i_pull_low(pull_low),
        .i_pin_o(O_RST_PIN_O), .i_pin_oe_n(O_RST_PIN_OE_N), .o_pin(I_RST_PIN_I),
        .o_pll_tick(I_PLL_TICK));
    initial begin
        I_CLK = 1'b0;
        forever #50 I_CLK = ~I_CLK;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ok(input string nm, input logic c);
        chk(nm, {31'h0, c}, 32'h1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge I_CLK);
        aw = 1'b1;
        w = 1'b1;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge I_CLK);
            if (aw && AWREADY) AWVALID <= 1'b0;
            if (w && WREADY) WVALID <= 1'b0;
            aw = aw && !AWREADY;
            w = w && !WREADY;
        end while (aw || w || !BVALID);
        resp = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar;
        @(posedge I_CLK);
        ar = 1'b1;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge I_CLK);
            if (ar && ARREADY) ARVALID <= 1'b0;
            ar = ar && !ARREADY;
        end while (ar || !RVALID);
        rd_data = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic hit(input logic [7:0] m);
        @(posedge I_CLK);
        src <= m;
        @(posedge I_CLK);
        src <= 8'h00;
    endtask
    task automatic pinlow(output int k);
        k = 0;
        while (O_RST_PIN_OE_N !== 1'b0) @(posedge I_CLK);
        ok("pin_driven", I_RST_PIN_I === 1'b0);
        while (O_RST_PIN_OE_N === 1'b0) begin
            @(posedge I_CLK);
            k++;
        end
    endtask
    task automatic until_en(output int k);
        k = 0;
        do begin
            @(posedge I_CLK);
            k++;
        end while (O_CPU_CLK_EN !== 1'b1 || O_INTERNAL_RESET !== 1'b0);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {I_RESET_N, I_POR, I_MONITOR_MODE, I_BREAK_STATE, I_TEST_HV_RST, I_TEST_HV_IRQ} = '0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, pll_run, pull_low} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hF;
        src = 8'h00;
        repeat (12) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        pinlow(n);
        ok("por_pin_low", n inside {[95:99]});
        until_en(n);
        rd(4'h8);
        chk("cause_por", rd_data, 32'h1);
        ok("clkgen_on", O_CLOCK_GEN_OUTPUT_EN === 1'b1);
        rd(4'h4);
        chk("option_rst", rd_data, 32'h0);
        wr(4'hC, 32'h1);
        chk("status_ro", 32'(resp), 32'h2);
        until_en(n);
        until_en(n);
        ok("periph_en", O_PERIPH_CLK_EN === 1'b1);
        chk("div_ref", n, 32'd4);
        wr(4'h0, 32'h1);
        pll_run <= 1'b1;
        repeat (3) until_en(n);
        chk("div_pll", n, 32'd8);
        $display("power-on and bus clock done");
        for (int i = 0; i < 6; i++) begin
            wr(4'h8, 32'h7F);
            wr(4'h0, 32'h1);
            hit(HIT[i]);
            pinlow(n);
            ok("pin_low", (i == 5) ? n inside {[95:99]} : n inside {[32:33]});
            until_en(n);
            rd(4'h8);
            chk("cause", rd_data, 32'(CAUSE[i]));
            rd(4'h0);
            chk("ctrl_cleared", rd_data, 32'h0);
            rd(4'hC);
            ok("cnt_cleared", rd_data[27:16] < 12'd200);
            repeat (2) until_en(n);
            chk("div_after", n, 32'd4);
        end
        for (int i = 0; i < 4; i++) begin
            wr(4'h4, 32'(OPT_S[i]));
            wr(4'h8, 32'h7F);
            hit(HIT_S[i]);
            repeat (8) @(posedge I_CLK);
            ok("no_reset", O_INTERNAL_RESET === 1'b0);
            rd(4'h8);
            chk("cause_none", rd_data, 32'h0);
        end
        $display("source resets done");
        for (int i = 0; i < 2; i++) begin
            wr(4'h8, 32'h7F);
            pull_low <= 1'b1;
            repeat (i ? 30 : 80) @(posedge I_CLK);
            pull_low <= 1'b0;
            until_en(n);
            rd(4'h8);
            chk("cause_pin", rd_data, i ? 32'h0 : 32'h2);
        end
        for (int i = 0; i < 2; i++) begin
            wr(4'h4, i ? 32'h10 : 32'h18);
            hit(8'h10);
            repeat (6) @(posedge I_CLK);
            rd(4'hC);
            chk("stopped", 32'(rd_data[27:0] & 28'hFFF0007), 32'h1);
            hit(8'h80);
            until_en(n);
            ok("stop_rec", (n inside {[32:37]}) == (i == 0));
        end
        $display("pin and stop done");
        I_MONITOR_MODE <= 1'b1;
        I_TEST_HV_RST <= 1'b1;
        repeat (4) @(posedge I_CLK);
        chk("vec_mon", 32'(O_RESET_VECTOR), 32'hFEFE);
        ok("wdog_off", O_WDOG_ENABLE === 1'b0);
        I_TEST_HV_RST <= 1'b0;
        I_TEST_HV_IRQ <= 1'b1;
        repeat (4) @(posedge I_CLK);
        ok("wdog_off_irq", O_WDOG_ENABLE === 1'b0);
        {I_MONITOR_MODE, I_TEST_HV_IRQ, I_BREAK_STATE, I_TEST_HV_RST} <= 4'h3;
        repeat (4) @(posedge I_CLK);
        ok("wdog_off_brk", O_WDOG_ENABLE === 1'b0);
        {I_BREAK_STATE, I_TEST_HV_RST} <= 2'h0;
        repeat (4) @(posedge I_CLK);
        chk("vec_user", 32'(O_RESET_VECTOR), 32'hFFFE);
        ok("wdog_on", O_WDOG_ENABLE === 1'b1);
        while (O_WDOG_CLK_EN !== 1'b1) @(posedge I_CLK);
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_WDOG_CLK_EN !== 1'b1);
        chk("wdog_period", n, 32'd4096);
        $display("monitor done");
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge I_CLK);
        errors++;
        wrap_up;
    end
endmodule // system_reset_clock_sequencer_tb
